// ---- logic/uobd_top.sv ----
// User option byte decoder: fetch, decode and watchdog start control
//
// Notes on behaviour
// (RULE1) Program memory bytes 0000H and 0001H hold the user option bits.
// (RULE2) Action bit 7 clear: watchdog time-out raises an interrupt request.
// (RULE3) Action bit 7 set: watchdog time-out causes a full system reset.
// (RULE4) Force bit 6 clear: watchdog runs from power-up, cannot be disabled.
// (RULE5) Force bit 6 set: watchdog idle until the start instruction.
// (RULE6) A started watchdog is stopped by reset only.
// (RULE7) Oscillator field 00 selects the external RC network.
// (RULE8) Oscillator field 01 selects minimum drive, 32 kHz to 1.0 MHz.
// (RULE9) Oscillator field 10 selects medium drive, 0.5 to 5.0 MHz.
// (RULE10) Oscillator field 11 selects maximum drive, 5.0 to 20.0 MHz.
// (RULE11) Erased byte decodes as reset action, instruction start, max drive.
// (RULE12) Resets never alter the stored option bytes.
// (RULE13) Each reset or stop recovery refetches the bytes before execution.
// (RULE14) After programming the bytes the system must be reset.
// (RULE15) Decoded settings stay static between resets.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "uobd_regs.svh"

module uobd_top (
	input  wire logic                    sys_clk,
	input  wire logic                    arst_n,
	// Stop-mode recovery pulse from the power controller
	input  wire logic                    stopRecover,
	// Program memory read port
	input  wire logic [7:0]              memData,
	output logic                         memRead,
	output logic [`UOBD_MEM_AW-1:0]      memAddr,
	// Watchdog side
	input  wire logic                    wdStartInstr,
	input  wire logic                    wdTimeout,
	output logic                         wdRunning,
	output logic                         wdIrqReq,
	output logic                         wdResetReq,
	output logic                         irqToCpu,
	// Settings and execution hold
	output uobd_pkg::uobd_cfg_t          cfgOut,
	output logic                         cfgValid,
	output logic                         cpuHold,
	// Software register port
	input  wire logic [`UOBD_RAW-1:0]    regAddr,
	input  wire logic [7:0]              regWdata,
	input  wire logic                    regWrite,
	input  wire logic                    regRead,
	output logic [7:0]                   regRdata
);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	////////////////////////////////////////////////////////////////////////
	// Decode of option byte zero
	function automatic uobd_pkg::uobd_cfg_t decodeByte(input logic [7:0] b);
		uobd_pkg::uobd_cfg_t c;
		c.actionReset  = b[`UOBD_ACT_BIT];
		c.startByInstr = b[`UOBD_FORCE_BIT];
		c.oscDrive     = uobd_pkg::uobd_osc_t'(b[`UOBD_OSC_HI:`UOBD_OSC_LO]);
		return c;
	endfunction : decodeByte

	logic       fetchLoaded;
	logic [7:0] optByte0;
	logic [7:0] optByte1;
	logic [7:0] ctrl_reg;
	logic       irqPend_reg;
	logic       timeoutHit;
	logic       pendClear;

	////////////////////////////////////////////////////////////////////////
	// Fetch of both option bytes; there is no path that writes memory
	uobd_fetch uFetch ( // RULE12
		.sys_clk      (sys_clk),
		.arst_n       (arst_n),
		.restartFetch (stopRecover),
		.memData      (memData),
		.memRead      (memRead),
		.memAddr      (memAddr),
		.optByte0     (optByte0),
		.optByte1     (optByte1),
		.loaded       (fetchLoaded)
	);

	// Byte one is latched but its bits drive nothing in this block
	logic unusedByte1;
	assign unusedByte1 = ^optByte1;

	////////////////////////////////////////////////////////////////////////
	// Configuration latches; reset value is the erased decode
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfgOut <= '{actionReset: 1'b1, startByInstr: 1'b1,
			            oscDrive: uobd_pkg::UOBD_OSC_HIGH}; // RULE11
		end else if (fetchLoaded && !cfgValid) begin
			cfgOut <= decodeByte(optByte0); // RULE7 RULE8 RULE9 RULE10
		end
	end

	// Settings are taken once per fetch and then held still
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfgValid <= 1'b0;
		end else begin
			cfgValid <= fetchLoaded; // RULE15
		end
	end

	// Execution is held until the latches hold fetched data
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cpuHold <= 1'b1;
		end else begin
			cpuHold <= !fetchLoaded; // RULE13
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog run control; nothing but arst_n clears it
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wdRunning <= 1'b0;
		end else if (cfgValid && !cfgOut.startByInstr) begin
			wdRunning <= 1'b1; // RULE4
		end else if (cfgValid && wdStartInstr) begin
			wdRunning <= 1'b1; // RULE5 RULE6
		end
	end

	// A time-out only counts while the watchdog is running
	assign timeoutHit = wdTimeout && wdRunning && cfgValid;

	// Time-out response pulses, steered by the action bit
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wdIrqReq   <= 1'b0;
			wdResetReq <= 1'b0;
		end else begin
			wdIrqReq   <= timeoutHit && !cfgOut.actionReset; // RULE2
			wdResetReq <= timeoutHit && cfgOut.actionReset;  // RULE3
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pending request: a new time-out wins over a clear in the same cycle
	assign pendClear = regWrite && (regAddr == `UOBD_REG_STATUS) &&
	                   regWdata[`UOBD_ST_PEND_BIT];

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irqPend_reg <= 1'b0;
		end else if (timeoutHit && !cfgOut.actionReset) begin
			irqPend_reg <= 1'b1; // RULE2
		end else if (pendClear) begin
			irqPend_reg <= 1'b0;
		end
	end

	// The processor sees the request only while interrupts are enabled
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irqToCpu <= 1'b0;
		end else begin
			irqToCpu <= irqPend_reg && ctrl_reg[`UOBD_CTRL_GIE_BIT]; // RULE2
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register: global interrupt enable only
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= `UOBD_CTRL_RESET;
		end else if (regWrite && regAddr == `UOBD_REG_CTRL) begin
			ctrl_reg <= {7'h00, regWdata[`UOBD_CTRL_GIE_BIT]};
		end
	end

	// Read port; the option latches themselves are not visible here
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdata <= `UOBD_RD_UNMAPPED;
		end else if (regRead) begin
			unique case (regAddr)
				`UOBD_REG_STATUS: regRdata <= {5'h00, irqPend_reg,
				                               wdRunning, cfgValid}; // RULE13
				`UOBD_REG_CTRL:   regRdata <= ctrl_reg;
				default:          regRdata <= `UOBD_RD_UNMAPPED;
			endcase
		end else begin
			regRdata <= `UOBD_RD_UNMAPPED;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	// Start of a fetch and its completion
	sequence fetchBegin;
		memRead && memAddr == `UOBD_OPT_ADDR0;
	endsequence

	sequence fetchEnd;
		memRead && memAddr == `UOBD_OPT_ADDR1 ##1 !memRead ##2 cfgValid;
	endsequence

	fetch_completes_a: // RULE13
	assert property (fetchBegin |-> ##1 fetchEnd)
		else $error("option fetch did not complete in time");

	only_option_locations_a: // RULE1
	assert property (memRead |-> memAddr <= `UOBD_OPT_ADDR1)
		else $error("fetch touched a non-option location");

	hold_until_valid_a: // RULE13
	assert property (!cfgValid |-> cpuHold)
		else $error("execution released before option load");

	irq_on_timeout_a: // RULE2
	assert property (timeoutHit && !cfgOut.actionReset
	                 |=> wdIrqReq && !wdResetReq && irqPend_reg)
		else $error("time-out did not raise an interrupt request");

	reset_on_timeout_a: // RULE3
	assert property (timeoutHit && cfgOut.actionReset
	                 |=> wdResetReq && !wdIrqReq)
		else $error("time-out did not request a system reset");

	forced_run_a: // RULE4
	assert property (cfgValid && !cfgOut.startByInstr |=> wdRunning)
		else $error("forced watchdog is not running");

	idle_until_start_a: // RULE5
	assert property (cfgValid && cfgOut.startByInstr && !wdRunning &&
	                 !wdStartInstr |=> !wdRunning)
		else $error("watchdog started without the instruction");

	started_by_instr_a: // RULE5
	assert property (cfgValid && wdStartInstr |=> wdRunning)
		else $error("start instruction ignored");

	never_stops_a: // RULE6
	assert property (wdRunning |=> wdRunning)
		else $error("running watchdog stopped without reset");

	osc_field_map_a: // RULE7
	assert property (cfgValid |-> cfgOut.oscDrive ==
	                 optByte0[`UOBD_OSC_HI:`UOBD_OSC_LO])
		else $error("oscillator drive does not match option field");

	erased_default_a: // RULE11
	assert property (cfgValid && optByte0 == `UOBD_ERASED_BYTE |->
	                 cfgOut.actionReset && cfgOut.startByInstr &&
	                 cfgOut.oscDrive == uobd_pkg::UOBD_OSC_HIGH)
		else $error("erased byte did not give the defaults");

	settings_static_a: // RULE15
	assert property (cfgValid && $past(cfgValid) |-> $stable(cfgOut))
		else $error("settings changed while valid");

	set_beats_clear_a: // RULE2
	assert property (timeoutHit && !cfgOut.actionReset && pendClear
	                 |=> irqPend_reg)
		else $error("pending request lost to a clear");

	fetch_starts_low_a: // RULE1
	assert property ($rose(memRead) |-> memAddr == `UOBD_OPT_ADDR0)
		else $error("fetch did not begin at the first option location");

	action_bit_map_a: // RULE3
	assert property (cfgValid |-> cfgOut.actionReset ==
	                 optByte0[`UOBD_ACT_BIT])
		else $error("time-out action does not match option bit");

	force_bit_map_a: // RULE4
	assert property (cfgValid |-> cfgOut.startByInstr ==
	                 optByte0[`UOBD_FORCE_BIT])
		else $error("watchdog start mode does not match option bit");

	no_request_idle_a: // RULE5
	assert property (!wdRunning |=> !wdIrqReq && !wdResetReq)
		else $error("time-out request while watchdog idle");

	irq_passes_enabled_a: // RULE2
	assert property (irqPend_reg && ctrl_reg[`UOBD_CTRL_GIE_BIT]
	                 |=> irqToCpu)
		else $error("enabled pending request not passed on");

	irq_masked_a: // RULE2
	assert property (!ctrl_reg[`UOBD_CTRL_GIE_BIT] |=> !irqToCpu)
		else $error("masked request reached the processor");

endmodule : uobd_top

// ---- pkg/uobd_regs.svh ----
// Offsets, field positions, reset values and widths of the option decoder
`ifndef UOBD_REGS_SVH
`define UOBD_REGS_SVH

// Program memory locations of the two user option bytes
`define UOBD_OPT_ADDR0      16'h0000
`define UOBD_OPT_ADDR1      16'h0001
`define UOBD_MEM_AW         16

// Field positions in option byte zero
`define UOBD_ACT_BIT        7
`define UOBD_FORCE_BIT      6
`define UOBD_OSC_HI         5
`define UOBD_OSC_LO         4

// Erased flash reads as all ones
`define UOBD_ERASED_BYTE    8'hFF

// Software register port
`define UOBD_RAW            4
`define UOBD_REG_STATUS     4'h0
`define UOBD_REG_CTRL       4'h1
`define UOBD_ST_VALID_BIT   0
`define UOBD_ST_RUN_BIT     1
`define UOBD_ST_PEND_BIT    2
`define UOBD_CTRL_GIE_BIT   0
`define UOBD_CTRL_RESET     8'h00
`define UOBD_RD_UNMAPPED    8'h00

`endif

// ---- pkg/uobd_pkg.sv ----
// Types shared by the option byte decoder modules
package uobd_pkg;

	// Oscillator drive levels, values as stored in the option byte
	typedef enum logic [1:0] {
		UOBD_OSC_RC     = 2'h0,
		UOBD_OSC_LOW    = 2'h1,
		UOBD_OSC_MEDIUM = 2'h2,
		UOBD_OSC_HIGH   = 2'h3
	} uobd_osc_t;

	// Decoded settings handed to the watchdog and oscillator
	typedef struct packed {
		logic      actionReset;
		logic      startByInstr;
		uobd_osc_t oscDrive;
	} uobd_cfg_t;

	// Fetch sequencer states
	typedef enum logic [4:0] {
		UOBD_F_START = 5'h01,
		UOBD_F_WAIT0 = 5'h02,
		UOBD_F_CAP0  = 5'h04,
		UOBD_F_CAP1  = 5'h08,
		UOBD_F_DONE  = 5'h10
	} uobd_fetch_t;

endpackage : uobd_pkg

// ---- logic/uobd_fetch.sv ----
// Fetch sequencer that reads both option bytes out of program memory
`timescale 1ns/100ps
`include "uobd_regs.svh"

module uobd_fetch (
	input  wire logic                    sys_clk,
	input  wire logic                    arst_n,
	input  wire logic                    restartFetch,
	input  wire logic [7:0]              memData,
	output logic                         memRead,
	output logic [`UOBD_MEM_AW-1:0]      memAddr,
	output logic [7:0]                   optByte0,
	output logic [7:0]                   optByte1,
	output logic                         loaded
);

	uobd_pkg::uobd_fetch_t state_reg;

	////////////////////////////////////////////////////////////////////////
	// Sequencer: a fetch starts by itself at reset release
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= uobd_pkg::UOBD_F_START;
		end else begin
			unique case (state_reg)
				uobd_pkg::UOBD_F_START: state_reg <= uobd_pkg::UOBD_F_WAIT0;
				uobd_pkg::UOBD_F_WAIT0: state_reg <= uobd_pkg::UOBD_F_CAP0;
				uobd_pkg::UOBD_F_CAP0:  state_reg <= uobd_pkg::UOBD_F_CAP1;
				uobd_pkg::UOBD_F_CAP1:  state_reg <= uobd_pkg::UOBD_F_DONE;
				uobd_pkg::UOBD_F_DONE: begin
					if (restartFetch) begin
						state_reg <= uobd_pkg::UOBD_F_START;
					end
				end
			endcase
		end
	end

	// Memory read strobe and address, only the two option locations
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			memRead <= 1'b0;
			memAddr <= `UOBD_OPT_ADDR0;
		end else begin
			memRead <= (state_reg == uobd_pkg::UOBD_F_START) ||
			           (state_reg == uobd_pkg::UOBD_F_WAIT0); // RULE1
			if (state_reg == uobd_pkg::UOBD_F_WAIT0) begin
				memAddr <= `UOBD_OPT_ADDR1; // RULE1
			end else if (state_reg == uobd_pkg::UOBD_F_START) begin
				memAddr <= `UOBD_OPT_ADDR0; // RULE1
			end
		end
	end

	// Capture: data stands one cycle after its strobe
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			optByte0 <= `UOBD_ERASED_BYTE;
			optByte1 <= `UOBD_ERASED_BYTE;
		end else begin
			if (state_reg == uobd_pkg::UOBD_F_CAP0) begin
				optByte0 <= memData; // RULE13
			end
			if (state_reg == uobd_pkg::UOBD_F_CAP1) begin
				optByte1 <= memData; // RULE13
			end
		end
	end

	// Loaded flag drops for the whole refetch
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			loaded <= 1'b0;
		end else if (state_reg == uobd_pkg::UOBD_F_CAP1) begin
			loaded <= 1'b1;
		end else if (state_reg == uobd_pkg::UOBD_F_DONE && restartFetch) begin
			loaded <= 1'b0;
		end
	end

endmodule : uobd_fetch

// ---- tb/uobd_prog_mem.sv ----
// Program memory model that holds the two user option bytes
`timescale 1ns/100ps
`include "uobd_regs.svh"

module uobd_prog_mem (
	input  wire logic                    sys_clk,
	input  wire logic                    memRead,
	input  wire logic [`UOBD_MEM_AW-1:0] memAddr,
	input  wire logic [7:0]              optByte0,
	input  wire logic [7:0]              optByte1,
	output logic [7:0]                   memData
);
	logic flip = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Read port: data in the cycle after the read; no reset input at all,
	// so no reset can change the stored bytes
	always @(posedge sys_clk) begin
		flip <= ~flip;
		if (memRead && memAddr == `UOBD_OPT_ADDR0)
			memData <= optByte0;
		else if (memRead && memAddr == `UOBD_OPT_ADDR1)
			memData <= optByte1;
		else
			memData <= flip ? 8'hA5 : 8'h5A; // Idle bus toggles, never holds
	end
endmodule : uobd_prog_mem

// ---- tb/user_option_byte_decode_test.sv ----
// Self-checking bench for the user option byte decoder
`timescale 1ns/100ps
`include "uobd_regs.svh"

`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
	fails++; $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module user_option_byte_decode_test;
	logic                       sys_clk      = 1'b0;
	logic                       arst_n       = 1'b0;
	logic                       stopRecover  = 1'b0;
	logic                       wdStartInstr = 1'b0;
	logic                       wdTimeout    = 1'b0;
	logic [3:0]                 regAddr      = 4'h0;
	logic [7:0]                 regWdata     = 8'h00;
	logic                       regWrite     = 1'b0;
	logic                       regRead      = 1'b0;
	logic [7:0]                 optByte0     = 8'hFF;
	logic [7:0]                 optByte1     = 8'hFF;
	logic [7:0]                 memData;
	logic                       memRead;
	logic [`UOBD_MEM_AW-1:0]    memAddr;
	logic                       wdRunning;
	logic                       wdIrqReq;
	logic                       wdResetReq;
	logic                       irqToCpu;
	uobd_pkg::uobd_cfg_t        cfgOut;
	logic                       cfgValid;
	logic                       cpuHold;
	logic [7:0]                 regRdata;
	int                         fails        = 0;
	int                         comparisons  = 0;
	logic [1:0]                 seen;
	logic                       lowSeen;
	logic [7:0]                 b;

	always #5 sys_clk = ~sys_clk;

	uobd_top uut (.sys_clk(sys_clk), .arst_n(arst_n),
		.stopRecover(stopRecover), .memData(memData), .memRead(memRead),
		.memAddr(memAddr), .wdStartInstr(wdStartInstr),
		.wdTimeout(wdTimeout), .wdRunning(wdRunning), .wdIrqReq(wdIrqReq),
		.wdResetReq(wdResetReq), .irqToCpu(irqToCpu), .cfgOut(cfgOut),
		.cfgValid(cfgValid), .cpuHold(cpuHold), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata));

	uobd_prog_mem mem (.sys_clk(sys_clk), .memRead(memRead),
		.memAddr(memAddr), .optByte0(optByte0), .optByte1(optByte1),
		.memData(memData));

	////////////////////////////////////////////////////////////////////////
	// Bus tasks; each starts on an edge so no strobe is set twice at once
	task automatic look(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : look

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr  <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [3:0] a, input logic [7:0] ex);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1;
		`CHK("regRdata", ex, regRdata)
	endtask : reg_read

	// Collect both request pulses over a few cycles; exact lag is not fixed
	task automatic timeout(output logic [1:0] s);
		@(posedge sys_clk);
		wdTimeout <= 1'b1;
		@(posedge sys_clk);
		wdTimeout <= 1'b0;
		s = 2'b00;
		repeat (3) begin
			#1 s = s | {wdIrqReq, wdResetReq};
			@(posedge sys_clk);
		end
	endtask : timeout

	task automatic wait_valid;
		int n;
		n = 0;
		do look(1); while (cfgValid !== 1'b1 && n++ < 20);
		`CHK("cfgValid", 1'b1, cfgValid)
		`CHK("cpuHold", 1'b0, cpuHold)
	endtask : wait_valid

	// New bytes only count after a reset, as the programming flow requires
	task automatic do_reset(input logic [7:0] ob);
		@(posedge sys_clk);
		optByte0 <= ob;
		arst_n   <= 1'b0;
		look(16);
		`CHK("cfgOut", 4'hF, cfgOut)
		`CHK("cpuHold", 1'b1, cpuHold)
		@(posedge sys_clk);
		arst_n <= 1'b1;
		wait_valid();
	endtask : do_reset

	task automatic stop_test;
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////////
	// Only the two option locations may ever be fetched
	always @(posedge sys_clk)
		if (arst_n && memRead === 1'b1)
			`CHK("memAddr", 1'b1, memAddr <= 16'h0001)

	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		do_reset(8'hFF);
		`CHK("cfgOut", 4'hF, cfgOut)
		look(3);
		`CHK("wdRunning", 1'b0, wdRunning)
		timeout(seen);
		`CHK("wdReq", 2'b00, seen)
		@(posedge sys_clk);
		wdStartInstr <= 1'b1;
		@(posedge sys_clk);
		wdStartInstr <= 1'b0;
		look(2);
		`CHK("wdRunning", 1'b1, wdRunning)
		timeout(seen);
		`CHK("wdReq", 2'b01, seen)
		@(posedge sys_clk);
		stopRecover <= 1'b1;
		@(posedge sys_clk);
		stopRecover <= 1'b0;
		lowSeen = 1'b0;
		repeat (4) begin
			look(1);
			lowSeen = lowSeen | (cfgValid === 1'b0);
		end
		`CHK("refetch", 1'b1, lowSeen)
		wait_valid();
		`CHK("wdRunning", 1'b1, wdRunning)
		`CHK("cfgOut", 4'hF, cfgOut)
		// Every drive code with both action choices; the start bit 6 copies drive bit 4
		for (int k = 0; k < 8; k++) begin
			b = {k[2], k[0], k[1:0], 4'hF};
			do_reset(b);
			`CHK("cfgOut", b[7:4], cfgOut)
			look(3);
			`CHK("wdRunning", ~b[6], wdRunning)
			if (!b[6]) begin
				timeout(seen);
				`CHK("wdReq", {~b[7], b[7]}, seen)
			end
		end
		// Interrupt path through the register port
		do_reset(8'h0F);
		reg_write(`UOBD_REG_CTRL, 8'hFF);
		reg_read(`UOBD_REG_CTRL, 8'h01);
		reg_read(4'hF, `UOBD_RD_UNMAPPED);
		timeout(seen);
		`CHK("wdReq", 2'b10, seen)
		look(1);
		`CHK("irqToCpu", 1'b1, irqToCpu)
		reg_read(`UOBD_REG_STATUS, 8'h07);
		reg_write(`UOBD_REG_STATUS, 8'h04);
		look(3);
		`CHK("irqToCpu", 1'b0, irqToCpu)
		reg_read(`UOBD_REG_STATUS, 8'h03);
		reg_write(`UOBD_REG_CTRL, 8'h00);
		timeout(seen);
		`CHK("wdReq", 2'b10, seen)
		look(3);
		`CHK("irqToCpu", 1'b0, irqToCpu)
		// A time-out in the cycle of a clear must leave the request pending
		reg_write(`UOBD_REG_STATUS, 8'h04);
		@(posedge sys_clk);
		wdTimeout <= 1'b1;
		regAddr   <= `UOBD_REG_STATUS;
		regWdata  <= 8'h04;
		regWrite  <= 1'b1;
		@(posedge sys_clk);
		wdTimeout <= 1'b0;
		regWrite  <= 1'b0;
		reg_read(`UOBD_REG_STATUS, 8'h07);
		stop_test();
	end
endmodule : user_option_byte_decode_test
